/* File: oai_fault_irq_port1.sv */
// Port 1 expander slice: serial register target, fault and change interrupt
`timescale 1ns/100ps
module oai_fault_irq_port1 #(
  parameter logic [6:0] TARGET_ADDR = oai_pkg::TARGET_ADDR,
  parameter int         PORT_W      = 8
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  input  wire logic              sclIn,
  input  wire logic              sdaIn,
  output logic                   sdaOut,
  output logic                   sdaOeN,
  input  wire logic [PORT_W-1:0] portIn,
  output logic      [PORT_W-1:0] portOut,
  output logic      [PORT_W-1:0] portOeN,
  output logic                   irqOutN,
  output logic                   irqOutOeN
);

  // ----------------------------------------
  // Pin synchronisers and edge finding
  // ----------------------------------------
  logic              sclS;
  logic              sdaS;
  logic [PORT_W-1:0] pinS;
  logic              sclD_r;
  logic              sdaD_r;

  oai_sync #(.WIDTH(PORT_W + 2)) uSync (
    .ref_clk (ref_clk),
    .asyncIn ({sclIn, sdaIn, portIn}),
    .syncOut ({sclS, sdaS, pinS})
  );

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      sclD_r <= 1'b1;
      sdaD_r <= 1'b1;
    end
    else
    begin
      sclD_r <= sclS;
      sdaD_r <= sdaS;
    end
  end

  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;

  assign sclRise   = sclS & ~sclD_r;
  assign sclFall   = ~sclS & sclD_r;
  assign startCond = sclS & sclD_r & sdaD_r & ~sdaS;
  assign stopCond  = sclS & sclD_r & ~sdaD_r & sdaS;

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic [PORT_W-1:0] outReg_r;
  logic [PORT_W-1:0] dirReg_r;
  logic [PORT_W-1:0] mask_r;
  logic [7:0]        ptr_r;
  logic [7:0]        shift_r;
  logic [7:0]        rdData;
  logic              wrStrobe;
  logic              rdStrobe;
  logic              inputRead;

  oai_pkg::oai_state_e state_r;
  logic [3:0]          bitCnt_r;
  logic                rw_r;
  logic                firstByte_r;
  logic                nack_r;
  logic                sdaDrive_r;

  always_comb
  begin
    case (ptr_r)
      oai_pkg::REG_INPUT_P1:      rdData = pinS;
      oai_pkg::REG_OUTPUT_P1:     rdData = outReg_r;
      oai_pkg::REG_DIR_P1:        rdData = dirReg_r;
      oai_pkg::REG_FAULT_MASK_P1: rdData = mask_r;
      default:                    rdData = oai_pkg::UNMAPPED_READ;
    endcase
  end

  assign wrStrobe  = (state_r == oai_pkg::ST_WR) && sclFall && !firstByte_r
                     && (bitCnt_r == oai_pkg::BITS_PER_BYTE);
  assign rdStrobe  = sclFall && rw_r && (((state_r == oai_pkg::ST_ACK))
                     || ((state_r == oai_pkg::ST_RACK) && !nack_r));
  assign inputRead = rdStrobe && (ptr_r == oai_pkg::REG_INPUT_P1);

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      outReg_r <= oai_pkg::RST_OUTPUT_P1;
      dirReg_r <= oai_pkg::RST_DIR_P1;
      mask_r   <= oai_pkg::RST_FAULT_MASK_P1;
    end
    else if (wrStrobe)
    begin
      case (ptr_r)
        oai_pkg::REG_OUTPUT_P1:     outReg_r <= shift_r;
        oai_pkg::REG_DIR_P1:        dirReg_r <= shift_r;
        oai_pkg::REG_FAULT_MASK_P1: mask_r   <= shift_r;
        default:                    mask_r   <= mask_r;
      endcase
    end
  end

  // ----------------------------------------
  // Serial target state machine
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      state_r     <= oai_pkg::ST_IDLE;
      bitCnt_r    <= 4'h0;
      shift_r     <= 8'h00;
      ptr_r       <= 8'h00;
      rw_r        <= 1'b0;
      firstByte_r <= 1'b1;
      nack_r      <= 1'b0;
      sdaDrive_r  <= 1'b0;
    end
    else if (startCond)
    begin
      state_r     <= oai_pkg::ST_ADDR;
      bitCnt_r    <= 4'h0;
      firstByte_r <= 1'b1;
      rw_r        <= 1'b0;
      sdaDrive_r  <= 1'b0;
    end
    else if (stopCond)
    begin
      state_r    <= oai_pkg::ST_IDLE;
      sdaDrive_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        oai_pkg::ST_ADDR, oai_pkg::ST_WR:
        begin
          if (sclRise && bitCnt_r < oai_pkg::BITS_PER_BYTE)
          begin
            shift_r  <= {shift_r[6:0], sdaS};
            bitCnt_r <= bitCnt_r + 4'h1;
          end
          else if (sclFall && bitCnt_r == oai_pkg::BITS_PER_BYTE)
          begin
            if (state_r == oai_pkg::ST_ADDR)
            begin
              if (shift_r[7:1] == TARGET_ADDR)
              begin
                rw_r       <= shift_r[0];
                sdaDrive_r <= 1'b1;
                state_r    <= oai_pkg::ST_ACK;
              end
              else
              begin
                state_r <= oai_pkg::ST_IDLE;
              end
            end
            else
            begin
              if (firstByte_r)
              begin
                ptr_r <= shift_r;
              end
              firstByte_r <= 1'b0;
              sdaDrive_r  <= 1'b1;
              state_r     <= oai_pkg::ST_ACK;
            end
          end
        end
        oai_pkg::ST_ACK:
        begin
          if (sclFall)
          begin
            if (rw_r)
            begin
              shift_r    <= rdData;
              sdaDrive_r <= ~rdData[7];
              bitCnt_r   <= 4'h1;
              state_r    <= oai_pkg::ST_RD;
            end
            else
            begin
              sdaDrive_r <= 1'b0;
              bitCnt_r   <= 4'h0;
              state_r    <= oai_pkg::ST_WR;
            end
          end
        end
        oai_pkg::ST_RD:
        begin
          if (sclFall)
          begin
            if (bitCnt_r == oai_pkg::BITS_PER_BYTE)
            begin
              sdaDrive_r <= 1'b0;
              nack_r     <= 1'b0;
              state_r    <= oai_pkg::ST_RACK;
            end
            else
            begin
              sdaDrive_r <= ~shift_r[6];
              shift_r    <= {shift_r[6:0], 1'b0};
              bitCnt_r   <= bitCnt_r + 4'h1;
            end
          end
        end
        oai_pkg::ST_RACK:
        begin
          if (sclRise)
          begin
            nack_r <= sdaS;
          end
          else if (sclFall)
          begin
            if (nack_r)
            begin
              state_r <= oai_pkg::ST_IDLE;
            end
            else
            begin
              shift_r    <= rdData;
              sdaDrive_r <= ~rdData[7];
              bitCnt_r   <= 4'h1;
              state_r    <= oai_pkg::ST_RD;
            end
          end
        end
        default:
        begin
          sdaDrive_r <= 1'b0;
        end
      endcase
    end
  end

  assign sdaOut = 1'b0;
  assign sdaOeN = ~sdaDrive_r;

  // ----------------------------------------
  // Port pins
  // ----------------------------------------
  assign portOut = outReg_r;
  assign portOeN = dirReg_r;

  // ----------------------------------------
  // Fault and change interrupt
  // ----------------------------------------
  logic [PORT_W-1:0] supp_r;
  logic [PORT_W-1:0] prevPin_r;
  logic [PORT_W-1:0] rawFault;
  logic [PORT_W-1:0] fault;
  logic [1:0]        armCnt_r;
  logic              armed;
  logic              inChg_r;
  logic              pinChange;

  assign rawFault  = mask_r & ~dirReg_r & (pinS ^ outReg_r);
  assign fault     = rawFault & ~supp_r;
  assign armed     = (armCnt_r == oai_pkg::ARM_CYCLES);
  assign pinChange = armed && |((pinS ^ prevPin_r) & dirReg_r);

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      supp_r <= oai_pkg::RST_SUPPRESS;
    end
    else if (wrStrobe && ptr_r == oai_pkg::REG_FAULT_MASK_P1)
    begin
      supp_r <= oai_pkg::RST_SUPPRESS;
    end
    else if (inputRead)
    begin
      supp_r <= supp_r | rawFault;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      armCnt_r  <= 2'h0;
      prevPin_r <= '0;
    end
    else
    begin
      armCnt_r  <= armed ? armCnt_r : armCnt_r + 2'h1;
      prevPin_r <= pinS;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      inChg_r <= 1'b0;
    end
    else if (pinChange)
    begin
      inChg_r <= 1'b1;
    end
    else if (inputRead)
    begin
      inChg_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      irqOutN <= 1'b1;
    end
    else
    begin
      irqOutN <= ~(inChg_r | (|fault));
    end
  end

  assign irqOutOeN = irqOutN;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence seqFaultRead;
    inputRead && (|rawFault);
  endsequence

  sequence seqQuietAfter;
    !inChg_r && !pinChange && $stable(mask_r);
  endsequence

  AST_MASK_RESET: assert property (@(posedge ref_clk) disable iff (1'b0)
    !rst_b |=> mask_r == '0)
    else $error("Fault mask not cleared by reset");
  AST_FAULT_ASSERT: assert property ((|fault) |=> !irqOutN)
    else $error("Masked output mismatch did not assert interrupt");
  AST_FAULT_WITHDRAW: assert property ((fault == '0) && !inChg_r |=> irqOutN)
    else $error("Interrupt not withdrawn after pin matched");
  AST_READ_ONCE: assert property (seqFaultRead ##1 seqQuietAfter |-> (fault == '0)
    || ($past(mask_r) != mask_r) || ($past(dirReg_r) != dirReg_r)
    || ($past(outReg_r) != outReg_r) || ($past(pinS) != pinS))
    else $error("Fault interrupt returned after input read");
  AST_MASK_ZERO: assert property ((mask_r == '0) && !inChg_r |=> irqOutN)
    else $error("Interrupt raised with empty fault mask");
  AST_CHANGE: assert property (pinChange |=> inChg_r ##1 !irqOutN)
    else $error("Input change did not assert interrupt");
  AST_RESET_IDLE: assert property (@(posedge ref_clk) disable iff (1'b0)
    !rst_b |=> irqOutN && !inChg_r
    && (supp_r == '0) && (state_r == oai_pkg::ST_IDLE))
    else $error("Reset left state behind");
  AST_DIR_PIN: assert property ($changed(dirReg_r) |-> $past(wrStrobe)
    && (portOeN == dirReg_r))
    else $error("Direction changed without a write");
  AST_INPUT_NOFAULT: assert property ((rawFault & dirReg_r) == '0)
    else $error("Input pin produced a fault");

endmodule // oai_fault_irq_port1

/* File: oai_pkg.sv */
// Constants and types for the port 1 output fault interrupt block
// Functional notes
// - Fault mask resets to all zeros
// - Masked output mismatch asserts the interrupt
// - Interrupt withdrawn once pin matches output
// - Input read clears fault interrupt only once
// - Unmasked pins never raise fault interrupt
// - Input pin change asserts interrupt, except in the first ARM_CYCLES cycles after reset
// - Reset returns all registers and state
// - Direction one is input, zero drives
package oai_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] REG_INPUT_P1      = 8'h01;
  localparam logic [7:0] REG_OUTPUT_P1     = 8'h03;
  localparam logic [7:0] REG_DIR_P1        = 8'h07;
  localparam logic [7:0] REG_FAULT_MASK_P1 = 8'h0b;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_OUTPUT_P1     = 8'hff;
  localparam logic [7:0] RST_DIR_P1        = 8'hff;
  localparam logic [7:0] RST_FAULT_MASK_P1 = 8'h00;
  localparam logic [7:0] RST_SUPPRESS      = 8'h00;
  localparam logic [7:0] UNMAPPED_READ     = 8'h00;

  // ----------------------------------------
  // Bus constants
  // ----------------------------------------
  // Arbitrary target address
  localparam logic [6:0] TARGET_ADDR   = 7'h22;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] ARM_CYCLES    = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK,
    ST_WR,
    ST_RD,
    ST_RACK
  } oai_state_e;

endpackage

/* File: oai_sync.sv */
// Two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/100ps
module oai_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge ref_clk)
  begin
    meta_r  <= asyncIn;
    syncOut <= meta_r;
  end

endmodule // oai_sync

/* File: oai_host_model.sv */
// Bus controller model that drives the serial register bus of the slice
`timescale 1ns/100ps
module oai_host_model (
  input  wire logic ref_clk,
  input  wire logic sdaWire,
  output logic      scl,
  output logic      sdaDrvN
);
  // ----------------------------------------
  // Bit level timing, 5 clk low and 3 clk high
  // ----------------------------------------
  initial
  begin
    scl     = 1'b1;
    sdaDrvN = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic bitIo(input logic b, output logic s);
    sdaDrvN = b;
    tick(4);
    scl = 1'b1;
    tick(2);
    s = sdaWire;
    tick(1);
    scl = 1'b0;
    tick(1);
  endtask

  task automatic startCond();
    sdaDrvN = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(2);
    sdaDrvN = 1'b0;
    tick(2);
    scl = 1'b0;
    tick(1);
  endtask

  task automatic stopCond();
    sdaDrvN = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(2);
    sdaDrvN = 1'b1;
    tick(4);
  endtask

  task automatic byteIo(input logic [7:0] d, input logic ackIn,
                        output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      bitIo(d[i], q[i]);
    end
    bitIo(ackIn, ack);
  endtask

  // ----------------------------------------
  // Register transfers
  // ----------------------------------------
  task automatic writeReg(input logic [6:0] addr, input logic [7:0] ptr,
                          input logic [7:0] data, output logic nack);
    logic [7:0] q;
    logic       a;
    startCond();
    byteIo({addr, 1'b0}, 1'b1, q, nack);
    byteIo(ptr, 1'b1, q, a);
    byteIo(data, 1'b1, q, a);
    stopCond();
  endtask

  task automatic readReg(input logic [7:0] ptr, output logic [7:0] data);
    logic [7:0] q;
    logic       a;
    startCond();
    byteIo({oai_pkg::TARGET_ADDR, 1'b0}, 1'b1, q, a);
    byteIo(ptr, 1'b1, q, a);
    startCond();
    byteIo({oai_pkg::TARGET_ADDR, 1'b1}, 1'b1, q, a);
    byteIo(8'hff, 1'b1, data, a);
    stopCond();
  endtask
endmodule // oai_host_model

/* File: tb_top.sv */
// Self-checking testbench for the port 1 fault interrupt slice
`timescale 1ns/100ps
module tb_top;
  logic       ref_clk;
  logic       rst_b;
  logic       scl;
  logic       sdaDrvN;
  logic       sdaWire;
  logic       sdaOut;
  logic       sdaOeN;
  logic       irqOutN;
  logic       irqOutOeN;
  logic       ack;
  logic [7:0] portIn;
  logic [7:0] portOut;
  logic [7:0] portOeN;
  logic [7:0] extPins;
  logic [7:0] shortMask;
  int         err_total;
  int         check_count;

  // ----------------------------------------
  // Wires, pull-up on data, shorts on outputs
  // ----------------------------------------
  assign sdaWire = sdaDrvN & sdaOeN;
  assign portIn  = (~portOeN & (portOut ^ shortMask)) | (portOeN & extPins);

  oai_fault_irq_port1 u_oai_fault_irq_port1 (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .sclIn     (scl),
    .sdaIn     (sdaWire),
    .sdaOut    (sdaOut),
    .sdaOeN    (sdaOeN),
    .portIn    (portIn),
    .portOut   (portOut),
    .portOeN   (portOeN),
    .irqOutN   (irqOutN),
    .irqOutOeN (irqOutOeN)
  );

  oai_host_model u_oai_host_model (
    .ref_clk (ref_clk),
    .sdaWire (sdaWire),
    .scl     (scl),
    .sdaDrvN (sdaDrvN)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic report_and_stop();
    if (err_total == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic doReset();
    @(negedge ref_clk);
    rst_b = 1'b0;
    repeat (20) @(negedge ref_clk);
    rst_b = 1'b1;
    repeat (8) @(negedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    u_oai_host_model.writeReg(oai_pkg::TARGET_ADDR, p, d, ack);
    chk({7'h00, ack}, 8'h00);
  endtask

  task automatic rdChk(input logic [7:0] p, input logic [7:0] e);
    logic [7:0] q;
    u_oai_host_model.readReg(p, q);
    chk(q, e);
  endtask

  task automatic irqIs(input logic e);
    repeat (12) @(negedge ref_clk);
    chk({7'h00, irqOutN}, {7'h00, e});
    chk({7'h00, irqOutOeN}, {7'h00, e});
  endtask

  initial
  begin
    repeat (60000) @(posedge ref_clk);
    err_total++;
    $display("ERROR %0t timeout before scenarios ended", $time);
    report_and_stop();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    err_total   = 0;
    check_count = 0;
    rst_b       = 1'b0;
    extPins     = 8'hf0;
    shortMask   = 8'h00;
    doReset();
    rdChk(oai_pkg::REG_FAULT_MASK_P1, 8'h00);
    chk(portOeN, 8'hff);
    chk({7'h00, sdaOut}, 8'h00);
    irqIs(1'b1);
    rdChk(8'h20, 8'h00);
    wr(oai_pkg::REG_DIR_P1, 8'hf0);
    wr(oai_pkg::REG_OUTPUT_P1, 8'h05);
    chk(portOeN, 8'hf0);
    chk(portOut, 8'h05);
    u_oai_host_model.writeReg(7'h23, oai_pkg::REG_OUTPUT_P1, 8'haa, ack);
    chk({7'h00, ack}, 8'h01);
    chk(portOut, 8'h05);
    rdChk(oai_pkg::REG_INPUT_P1, 8'hf5);
    shortMask = 8'h01;
    irqIs(1'b1);
    wr(oai_pkg::REG_FAULT_MASK_P1, 8'h23);
    rdChk(oai_pkg::REG_FAULT_MASK_P1, 8'h23);
    irqIs(1'b0);
    shortMask = 8'h00;
    irqIs(1'b1);
    shortMask = 8'h02;
    irqIs(1'b0);
    rdChk(oai_pkg::REG_INPUT_P1, 8'hf7);
    irqIs(1'b1);
    shortMask = 8'h00;
    repeat (12) @(negedge ref_clk);
    shortMask = 8'h02;
    irqIs(1'b1);
    extPins = 8'he0;
    irqIs(1'b0);
    rdChk(oai_pkg::REG_INPUT_P1, 8'he7);
    irqIs(1'b1);
    wr(oai_pkg::REG_FAULT_MASK_P1, 8'h00);
    extPins = 8'hf0;
    irqIs(1'b0);
    wr(oai_pkg::REG_FAULT_MASK_P1, 8'h02);
    doReset();
    irqIs(1'b1);
    chk(portOeN, 8'hff);
    chk(portOut, 8'hff);
    rdChk(oai_pkg::REG_FAULT_MASK_P1, 8'h00);
    report_and_stop();
  end
endmodule // tb_top
